// ### common/bed_pkg.sv
// shared constants and types of the bus event detector
package bed_pkg;

  // ********************************
  // channel layout
  // ********************************
  localparam int NUM_FULL  = 8;
  localparam int NUM_RANGE = 4;
  localparam int NUM_CH    = NUM_FULL + NUM_RANGE;
  localparam int TRIG_CH   = 7;   // channel eight, zero based
  localparam int CNT_W     = 16;

  // ********************************
  // register map: channel c at byte c*0x20
  // ********************************
  localparam logic [3:0] W_ADDR_LO = 4'h0;
  localparam logic [3:0] W_ADDR_HI = 4'h1;
  localparam logic [3:0] W_DATA    = 4'h2;
  localparam logic [3:0] W_MASK    = 4'h3;
  localparam logic [3:0] W_CTRL    = 4'h4;
  localparam logic [3:0] W_COUNT   = 4'h5;
  localparam logic [3:0] W_SEQ     = 4'h6;
  localparam int         CH_WORDS  = 8;
  localparam logic [11:0] STATUS_ADDR = 12'h180;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;

  // ********************************
  // control word fields
  // ********************************
  localparam int F_AMODE   = 0;   // 2 bits
  localparam int F_OUTSIDE = 2;
  localparam int F_DIR     = 3;   // 2 bits
  localparam int F_DCMP    = 5;
  localparam int F_UMASK   = 6;
  localparam int F_WORD    = 7;
  localparam int F_STATE   = 8;   // 3 bits
  localparam int F_SCARE   = 11;
  localparam int F_AREA    = 12;  // 3 bits
  localparam int F_ACARE   = 15;
  localparam int F_PCARE   = 16;  // 4 bits
  localparam int F_PLVL    = 20;  // 4 bits
  localparam int F_ACT     = 24;  // 2 bits
  localparam int F_SEQEN   = 26;
  localparam int F_PASS    = 0;   // count word, 16 bits
  localparam int F_DELAY   = 16;  // count word, 16 bits
  localparam int F_ARM     = 0;   // seq word, 8 bits
  localparam int F_NOOCC   = 8;
  localparam int F_RST     = 16;  // seq word, 8 bits
  localparam int F_DLY_BUSY = 16; // status word

  typedef enum logic [1:0] {
    bed_amode_ignore = 2'h0,
    bed_amode_single = 2'h1,
    bed_amode_range  = 2'h2
  } bed_amode_t;

  typedef enum logic [1:0] {
    bed_dir_either = 2'h0,
    bed_dir_read   = 2'h1,
    bed_dir_write  = 2'h2
  } bed_dir_t;

  typedef enum logic [1:0] {
    bed_act_break = 2'h0,
    bed_act_start = 2'h1,
    bed_act_stop  = 2'h2,
    bed_act_none  = 2'h3
  } bed_act_t;

  typedef enum logic [2:0] {
    prefetch_cycle_state            = 3'h0,
    data_cycle_state                = 3'h1,
    refresh_cycle_state             = 3'h2,
    dma_cycle_state                 = 3'h3,
    transfer_controller_cycle_state = 3'h4,
    other_cycle_state               = 3'h5
  } bed_state_t;

  typedef enum logic [2:0] {
    rom_area                     = 3'h0,
    ram_area                     = 3'h1,
    onchip_wide_io_area          = 3'h2,
    onchip_narrow_io_area        = 3'h3,
    external_wide_io_area        = 3'h4,
    external_narrow_io_area      = 3'h5,
    transfer_controller_ram_area = 3'h6
  } bed_area_t;

  // one monitored bus cycle, captured together
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic        wr;
    logic        word;
    logic [2:0]  state;
    logic [2:0]  area;
    logic [3:0]  probe;
  } bed_cycle_t;

endpackage : bed_pkg

// ### verilog/bed_detector.sv
// event detection channels of the bus monitor with apb configuration
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
module bed_detector
  import bed_pkg::*;
(
  input  wire logic        ref_clk_i,         // 40 MHz clock
  input  wire logic        rstn_i,            // async reset, low
  input  wire logic        psel_i,            // apb select
  input  wire logic        penable_i,         // apb access phase
  input  wire logic        pwrite_i,          // apb direction
  input  wire logic [11:0] paddr_i,           // apb byte address
  input  wire logic [31:0] pwdata_i,          // apb write data
  output logic      [31:0] prdata_o,          // apb read data
  output logic             pready_o,          // apb ready
  output logic             pslverr_o,         // apb error, unmapped
  input  wire logic        run_i,             // user program running
  input  wire logic        bus_cycle_i,       // one pulse per bus cycle
  input  wire bed_cycle_t  cycle_i,           // monitored cycle content
  output logic             break_o,           // break request pulse
  output logic             timer_start_o,     // run timer start pulse
  output logic             timer_stop_o,      // run timer stop pulse
  output logic             trigger_probe_line_n_o, // trigger, low one bus cycle
  output logic [NUM_CH-1:0] satisfied_o       // latched channel states
);

  // ********************************
  // configuration storage and apb slave
  // ********************************
  logic [31:0] cfg [NUM_CH*CH_WORDS];
  logic [3:0]  a_ch;
  logic [3:0]  a_wd;
  logic        a_cfg;
  logic        a_stat;
  logic [6:0]  a_idx;
  logic        acc;
  logic        a_blk_ok;
  logic        a_ch_ok;
  logic        a_wd_ok;
  logic        a_align_ok;

  assign a_ch   = paddr_i[8:5];
  assign a_wd   = {1'b0, paddr_i[4:2]};
  // upper address bits must be zero so no alias of a channel word answers
  assign a_blk_ok   = (paddr_i[11:9] == 3'h0);
  assign a_ch_ok    = (a_ch < 4'(NUM_CH));
  assign a_wd_ok    = (a_wd <= W_SEQ);
  assign a_align_ok = (paddr_i[1:0] == 2'h0);
  assign a_cfg      = a_blk_ok && a_ch_ok && a_wd_ok && a_align_ok;
  assign a_stat = (paddr_i == STATUS_ADDR);
  assign a_idx  = {a_ch, a_wd[2:0]};
  assign acc    = psel_i && penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !(a_cfg || a_stat);

  logic [NUM_CH-1:0] sat;
  logic              dly_busy;
  logic [31:0]       status_word;

  // ********************************
  // status word
  // ********************************
  // unused status bits read as zero
  always_comb begin
    status_word             = 32'h0000_0000;
    status_word[NUM_CH-1:0] = sat;
    status_word[F_DLY_BUSY] = dly_busy;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_CH*CH_WORDS; i++) begin
        cfg[i] <= CFG_RESET;
      end
    end else if (acc && pwrite_i && a_cfg) begin
      cfg[a_idx] <= pwdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (a_cfg) begin
        prdata_o <= cfg[a_idx];
      end else if (a_stat) begin
        prdata_o <= status_word;
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // ********************************
  // bus cycle capture
  // ********************************
  // all fields latched on the same strobe so channels see one coherent cycle
  bed_cycle_t smp;
  logic       smp_vld;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      smp <= '0;
    end else if (bus_cycle_i) begin
      smp <= cycle_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      smp_vld <= 1'b0;
    end else begin
      smp_vld <= bus_cycle_i && run_i;
    end
  end

  // ********************************
  // channels
  // ********************************
  logic [NUM_CH-1:0] fire;
  logic [NUM_CH-1:0] act_brk;
  logic [NUM_CH-1:0] act_start;
  logic [NUM_CH-1:0] act_stop;
  logic [CNT_W-1:0]  dly_val [NUM_CH];

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      localparam bit FULL = (c < NUM_FULL);
      logic [31:0] ctl;
      logic [31:0] cnt;
      logic [31:0] seq;
      logic [23:0] lo;
      logic [23:0] hi;
      logic [15:0] msk;
      logic        in_rng;
      logic        addr_ok;
      logic        dir_ok;
      logic        data_ok;
      logic        state_ok;
      logic        area_ok;
      logic        probe_ok;
      logic        cond;
      logic        armed;
      logic        rst_hit;
      logic        seq_on;
      logic [NUM_FULL-1:0] arm_m;
      logic [NUM_FULL-1:0] rst_m;
      logic [CNT_W-1:0] pass;
      logic [CNT_W-1:0] hits;
      logic [CNT_W:0]   hits_nx;
      bed_act_t         act;

      assign ctl = cfg[c*CH_WORDS + int'(W_CTRL)];
      assign cnt = cfg[c*CH_WORDS + int'(W_COUNT)];
      assign seq = cfg[c*CH_WORDS + int'(W_SEQ)];
      assign lo  = cfg[c*CH_WORDS + int'(W_ADDR_LO)][23:0];
      assign hi  = cfg[c*CH_WORDS + int'(W_ADDR_HI)][23:0];

      always_comb begin
        case (bed_amode_t'(ctl[F_AMODE +: 2]))
          bed_amode_single: in_rng = (smp.addr == lo);
          bed_amode_range:  in_rng = (smp.addr >= lo) && (smp.addr <= hi);
          default:          in_rng = 1'b1;
        endcase
      end

      // outside test exists on full channels only
      assign addr_ok = (ctl[F_AMODE +: 2] == bed_amode_ignore) ? 1'b1
                       : (in_rng ^ (FULL && ctl[F_OUTSIDE]));

      always_comb begin
        case (bed_dir_t'(ctl[F_DIR +: 2]))
          bed_dir_read:  dir_ok = !smp.wr;
          bed_dir_write: dir_ok = smp.wr;
          default:       dir_ok = 1'b1;
        endcase
      end

      assign msk     = ctl[F_UMASK] ? cfg[c*CH_WORDS + int'(W_MASK)][15:0] : 16'hFFFF;
      assign data_ok = !ctl[F_DCMP]
                       || (((smp.data & msk) == (cfg[c*CH_WORDS + int'(W_DATA)][15:0] & msk))
                           && (smp.word == ctl[F_WORD]));
      assign state_ok = !ctl[F_SCARE] || (smp.state == ctl[F_STATE +: 3]);
      assign area_ok  = !ctl[F_ACARE] || (smp.area == ctl[F_AREA +: 3]);
      assign probe_ok = &(~ctl[F_PCARE +: 4] | ~(smp.probe ^ ctl[F_PLVL +: 4]));
      assign cond     = smp_vld && addr_ok && dir_ok && data_ok
                        && state_ok && area_ok && probe_ok;

      // sequencing only among the full channels
      assign seq_on  = FULL && ctl[F_SEQEN];
      assign arm_m   = seq[F_ARM +: NUM_FULL];
      assign rst_m   = seq[F_RST +: NUM_FULL];
      assign armed   = !seq_on || (arm_m == '0)
                       || (seq[F_NOOCC] ? |(arm_m & ~sat[NUM_FULL-1:0])
                                        : |(arm_m & sat[NUM_FULL-1:0]));
      assign rst_hit = seq_on && |(rst_m & fire[NUM_FULL-1:0]);

      // pass counts of zero and one both fire on the first match
      assign pass    = FULL ? cnt[F_PASS +: CNT_W] : 16'h0001;
      assign hits_nx = {1'b0, hits} + 17'h00001;
      assign fire[c] = cond && armed && !sat[c] && (hits_nx >= {1'b0, pass});

      // a stop or reset event forgets the matches counted so far
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          hits <= '0;
        end else if (!run_i || rst_hit) begin
          hits <= '0;
        end else if (cond && armed && !sat[c] && !fire[c]) begin
          hits <= hits_nx[CNT_W-1:0];
        end
      end

      // set wins over a reset arriving in the same cycle
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sat[c] <= 1'b0;
        end else if (!run_i) begin
          sat[c] <= 1'b0;
        end else if (fire[c]) begin
          sat[c] <= 1'b1;
        end else if (rst_hit) begin
          sat[c] <= 1'b0;
        end
      end

      assign act          = bed_act_t'(ctl[F_ACT +: 2]);
      assign act_brk[c]   = fire[c] && (act == bed_act_break);
      assign act_start[c] = FULL && fire[c] && (act == bed_act_start);
      assign act_stop[c]  = FULL && fire[c] && (act == bed_act_stop);
      assign dly_val[c]   = cnt[F_DELAY +: CNT_W];
    end
  endgenerate

  assign satisfied_o = sat;

  // ********************************
  // actions and shared delay counter
  // ********************************
  // one counter only; a second delayed break while it runs is dropped
  logic             brk_now;
  logic             dly_load;
  logic [CNT_W-1:0] dly_pick;
  logic [CNT_W-1:0] dly_cnt;
  logic             dly_done;

  always_comb begin
    brk_now  = 1'b0;
    dly_load = 1'b0;
    dly_pick = '0;
    for (int i = NUM_CH-1; i >= 0; i--) begin
      if (act_brk[i] && dly_val[i] == '0) begin
        brk_now = 1'b1;
      end
      if (act_brk[i] && dly_val[i] != '0) begin
        dly_load = 1'b1;
        dly_pick = dly_val[i];
      end
    end
  end

  assign dly_done = dly_busy && smp_vld && (dly_cnt == 16'h0001);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_busy <= 1'b0;
      dly_cnt  <= '0;
    end else if (!run_i) begin
      dly_busy <= 1'b0;
      dly_cnt  <= '0;
    end else if (dly_busy) begin
      if (smp_vld) begin
        dly_cnt  <= dly_cnt - 16'h0001;
        dly_busy <= (dly_cnt != 16'h0001);
      end
    end else if (dly_load) begin
      dly_busy <= 1'b1;
      dly_cnt  <= dly_pick;
    end
  end

  // gated by run so a stop in the same cycle swallows a pending break
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      break_o <= 1'b0;
    end else begin
      break_o <= run_i && (brk_now || dly_done);
    end
  end

  // timer pulses never wait: the delay counter serves breaks only
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_start_o <= 1'b0;
    end else begin
      timer_start_o <= |act_start;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_stop_o <= 1'b0;
    end else begin
      timer_stop_o <= |act_stop;
    end
  end

  // ********************************
  // trigger probe output
  // ********************************
  // low from the match until the next bus cycle strobe
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trigger_probe_line_n_o <= 1'b1;
    end else if (fire[TRIG_CH]) begin
      trigger_probe_line_n_o <= 1'b0;
    end else if (bus_cycle_i || !run_i) begin
      trigger_probe_line_n_o <= 1'b1;
    end
  end

endmodule : bed_detector

// ### test/bed_detector_properties.sv
// port assertions of the bus event detector
`timescale 1ns/10ps
module bed_detector_properties
  import bed_pkg::*;
(
  input wire logic              ref_clk_i,              // clock
  input wire logic              rstn_i,                 // reset, low
  input wire logic              psel_i,                 // apb select
  input wire logic              penable_i,              // apb enable
  input wire logic              pwrite_i,               // apb write
  input wire logic [11:0]       paddr_i,                // apb address
  input wire logic [31:0]       pwdata_i,               // apb data
  input wire logic [31:0]       prdata_o,               // read data
  input wire logic              pready_o,               // ready
  input wire logic              pslverr_o,              // error
  input wire logic              run_i,                  // running
  input wire logic              bus_cycle_i,            // bus cycle
  input wire bed_cycle_t        cycle_i,                // cycle content
  input wire logic              break_o,                // break
  input wire logic              timer_start_o,          // timer start
  input wire logic              timer_stop_o,           // timer stop
  input wire logic              trigger_probe_line_n_o, // trigger
  input wire logic [NUM_CH-1:0] satisfied_o             // states
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ****
  // sequences
  // ****
  sequence s_access;
    psel_i && penable_i;
  endsequence
  sequence s_fire8;
    $rose(satisfied_o[TRIG_CH]);
  endsequence
  // capture edge, compare cycle, then the latch edge
  sequence s_new_sat;
    (satisfied_o & ~$past(satisfied_o)) != '0;
  endsequence
  // ****
  // assertions
  // ****
  AST_READY: assert property (s_access |-> pready_o)
    else $error("access phase without ready");
  AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
  AST_TRIG_LOW: assert property (s_fire8 |-> !trigger_probe_line_n_o)
    else $error("trigger not low on channel eight");
  AST_TRIG_CAUSE: assert property ($fell(trigger_probe_line_n_o) |-> s_fire8)
    else $error("trigger low without channel eight");
  AST_TRIG_END: assert property (!trigger_probe_line_n_o && bus_cycle_i |-> ##[1:2] trigger_probe_line_n_o)
    else $error("trigger low past one bus cycle");
  AST_STOP_CLR: assert property (!run_i |=> satisfied_o == '0)
    else $error("states kept while stopped");
  AST_SAT_CAUSE: assert property (s_new_sat |-> $past(bus_cycle_i, 2))
    else $error("state set without a bus cycle");
  AST_BRK_PULSE: assert property (break_o |=> !break_o)
    else $error("break longer than one cycle");
  AST_TSTART_PULSE: assert property (timer_start_o |=> !timer_start_o)
    else $error("timer start longer than one cycle");
  AST_TSTOP_PULSE: assert property (timer_stop_o |=> !timer_stop_o)
    else $error("timer stop longer than one cycle");
  AST_UNMAPPED_RD: assert property (psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == '0)
    else $error("unmapped read returned data");
  AST_STAT_RSVD: assert property (psel_i && penable_i && !pwrite_i && paddr_i == STATUS_ADDR
                                  |-> (prdata_o >> (F_DLY_BUSY + 1)) == '0
                                      && prdata_o[F_DLY_BUSY-1:NUM_CH] == '0)
    else $error("reserved status bits set");
endmodule : bed_detector_properties

bind bed_detector bed_detector_properties u_bed_detector_properties (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .run_i(run_i), .bus_cycle_i(bus_cycle_i), .cycle_i(cycle_i), .break_o(break_o),
  .timer_start_o(timer_start_o), .timer_stop_o(timer_stop_o),
  .trigger_probe_line_n_o(trigger_probe_line_n_o), .satisfied_o(satisfied_o));

// ### test/bed_bus_model.sv
// monitored bus side: issues one bus cycle at a time
`timescale 1ns/10ps
module bed_bus_model
  import bed_pkg::*;
(
  input  wire logic ref_clk_i,   // bench clock
  output logic      bus_cycle_o, // one pulse per cycle
  output bed_cycle_t cycle_o     // cycle content
);
  initial begin
    bus_cycle_o = 1'b0;
    cycle_o     = '0;
  end
  // gap sets how slowly the bus runs, at least one idle clock
  task automatic send(input bed_cycle_t c, input int gap);
    @(posedge ref_clk_i);
    bus_cycle_o <= 1'b1;
    cycle_o     <= c;
    @(posedge ref_clk_i);
    bus_cycle_o <= 1'b0;
    cycle_o     <= ~c; // released bus, no stale value
    repeat (gap) @(posedge ref_clk_i);
  endtask : send
endmodule : bed_bus_model

// ### test/test_bus_event_detector.sv
// self-checking bench of the bus event detector
`timescale 1ns/10ps
module test_bus_event_detector
  import bed_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              rstn_i    = 1'b0;
  logic              psel_i    = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i  = 1'b0;
  logic [11:0]       paddr_i   = 12'h000;
  logic [31:0]       pwdata_i  = 32'h0000_0000;
  logic              run_i     = 1'b0;
  logic              bus_cycle_i, pready_o, pslverr_o, er, break_o, timer_start_o, timer_stop_o, trig_n;
  logic [31:0]       prdata_o, rd;
  logic [NUM_CH-1:0] sat;
  bed_cycle_t        cycle_i, c0;
  int                cnt [3];
  int                n_fail  = 0;
  int                checked = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cnt[0] += int'(break_o === 1'b1);
    cnt[1] += int'(timer_start_o === 1'b1);
    cnt[2] += int'(timer_stop_o === 1'b1);
  end

  bed_detector u_bed_detector (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .run_i(run_i), .bus_cycle_i(bus_cycle_i), .cycle_i(cycle_i), .break_o(break_o),
    .timer_start_o(timer_start_o), .timer_stop_o(timer_stop_o), .trigger_probe_line_n_o(trig_n),
    .satisfied_o(sat));
  bed_bus_model u_bed_bus_model (.ref_clk_i(ref_clk_i), .bus_cycle_o(bus_cycle_i), .cycle_o(cycle_i));

  task automatic finish_test();
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 64);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED apb ready expected 1 seen %b", pready_o);
      finish_test();
    end
  endtask : apb

  function automatic bed_cycle_t cy(logic [23:0] a, logic w = 1'b0, logic wd = 1'b0, logic [2:0] s = 3'h0,
                                    logic [2:0] r = 3'h0, logic [3:0] p = 4'h0);
    cy = '{addr: a, data: 16'hAB34, wr: w, word: wd, state: s, area: r, probe: p};
  endfunction : cy

  // low 0x100, high 0x1FF, value 0x1234, mask 0x00FF on the channel given
  task automatic cfg(input int ch, input logic [31:0] ctl, input logic [31:0] cn, input logic [31:0] sq);
    logic [31:0] v [7];
    v = '{32'h0000_0100, 32'h0000_01FF, 32'h0000_1234, 32'h0000_00FF, ctl, cn, sq};
    foreach (v[i]) apb(1'b1, 12'(ch * 32 + i * 4), v[i]);
  endtask : cfg

  // a stop and restart clears every state
  task automatic rerun();
    @(posedge ref_clk_i);
    run_i <= 1'b0;
    @(posedge ref_clk_i);
    run_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    cnt = '{0, 0, 0};
  endtask : rerun

  task automatic go(input bed_cycle_t c, input int gap = 1);
    u_bed_bus_model.send(c, gap);
    @(posedge ref_clk_i);
    #1;
  endtask : go

  task automatic tr(input logic [31:0] ctl, input bed_cycle_t c, input logic e);
    cfg(0, ctl, 32'h0000_0000, 32'h0000_0000);
    rerun();
    go(c);
    chk("channel one", 32'(e), 32'(sat[0]));
    chk("break count", 32'(e), 32'(cnt[0]));
  endtask : tr

  task automatic t_regs();
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("control reset", CFG_RESET, rd);
    apb(1'b1, 12'h160, 32'h00AB_CDEF);
    apb(1'b0, 12'h160, 32'h0000_0000);
    chk("low address", 32'h00AB_CDEF, rd);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(er));
    chk("unmapped data", 32'h0000_0000, rd);
    // park every channel on a single address with no action, so no stray break: zero, except 0xABCDEF on channel 11
    for (int c = 0; c < NUM_CH; c++) apb(1'b1, 12'(c * 32 + 16), 32'h0300_0001);
  endtask : t_regs

  task automatic t_match();
    tr(32'h0000_0000, cy(24'h000123, 1'b1, 1'b0, 3'h5, 3'h6, 4'hF), 1'b1);
    tr(32'h0000_0001, cy(24'h000100), 1'b1);
    tr(32'h0000_0001, cy(24'h000101), 1'b0);
    tr(32'h0000_0002, cy(24'h0001FF), 1'b1);
    tr(32'h0000_0002, cy(24'h000200), 1'b0);
    tr(32'h0000_0006, cy(24'h000200), 1'b1);
    tr(32'h0000_0006, cy(24'h000150), 1'b0);
    tr(32'h0000_0005, cy(24'h000101), 1'b1);
    tr(32'h0000_00E0, cy(24'h000000, 1'b0, 1'b1), 1'b1);
    tr(32'h0000_00A0, cy(24'h000000, 1'b0, 1'b1), 1'b0);
    tr(32'h0000_00E0, cy(24'h000000, 1'b0, 1'b0), 1'b0);
    tr(32'h0000_0008, cy(24'h000000, 1'b0), 1'b1);
    tr(32'h0000_0008, cy(24'h000000, 1'b1), 1'b0);
    tr(32'h0000_0010, cy(24'h000000, 1'b1), 1'b1);
    tr(32'h0000_0009, cy(24'h000100, 1'b1), 1'b0);
    for (int i = 0; i < 6; i++) begin
      tr(32'h0000_0800 | (i << 8), cy(.a(24'h000000), .s(3'(i))), 1'b1);
      tr(32'h0000_0800 | (i << 8), cy(.a(24'h000000), .s(3'((i + 1) % 6))), 1'b0);
    end
    for (int i = 0; i < 7; i++) begin
      tr(32'h0000_8000 | (i << 12), cy(.a(24'h000000), .r(3'(i))), 1'b1);
      tr(32'h0000_8000 | (i << 12), cy(.a(24'h000000), .r(3'((i + 1) % 7))), 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      tr(32'h0011_0000 << i, cy(.a(24'h000000), .p(4'(1 << i))), 1'b1);
      tr(32'h0001_0000 << i, cy(.a(24'h000000), .p(4'(1 << i))), 1'b0);
      tr(32'h0001_0000 << i, cy(.a(24'h000000), .p(4'hF ^ 4'(1 << i))), 1'b1);
    end
  endtask : t_match

  task automatic t_pass();
    cfg(0, 32'h0000_0000, 32'h0000_0003, 32'h0000_0000);
    rerun();
    go(c0, 3);
    go(c0);
    chk("pass two", 32'h0000_0000, 32'(sat[0]));
    go(c0);
    chk("pass three", 32'h0000_0001, 32'(sat[0]));
    go(c0);
    chk("one break", 32'h0000_0001, 32'(cnt[0]));
  endtask : t_pass

  task automatic t_delay();
    cfg(0, 32'h0000_0000, 32'h0002_0000, 32'h0000_0000);
    rerun();
    go(c0);
    apb(1'b0, STATUS_ADDR, 32'h0000_0000);
    chk("delay running", 32'h0000_0001, 32'(rd[F_DLY_BUSY]));
    go(c0);
    chk("no early break", 32'h0000_0000, 32'(cnt[0]));
    go(c0, 3);
    chk("delayed break", 32'h0000_0001, 32'(cnt[0]));
  endtask : t_delay

  task automatic t_actions();
    for (int a = 0; a < 4; a++) begin
      cfg(0, 32'(a) << 24, 32'h0000_0000, 32'h0000_0000);
      rerun();
      go(c0, 3);
      for (int i = 0; i < 3; i++) chk("action pulses", 32'(a == i), 32'(cnt[i]));
    end
  endtask : t_actions

  task automatic t_seq();
    cfg(0, 32'h0400_0001, 32'h0000_0000, 32'h0002_0000);
    cfg(1, 32'h0700_0000, 32'h0000_0000, 32'h0000_0001);
    rerun();
    go(cy(24'h000150));
    chk("unarmed", 32'h0000_0000, 32'(sat[1:0]));
    go(c0);
    chk("arming stage", 32'h0000_0001, 32'(sat[0]));
    go(cy(24'h000150));
    chk("armed and reset", 32'h0000_0002, 32'(sat[1:0]));
  endtask : t_seq

  task automatic t_tail();
    // range channel: outside flag and pass count have no effect
    cfg(8, 32'h0300_0006, 32'h0000_0003, 32'h0000_0000);
    cfg(7, 32'h0300_0000, 32'h0000_0000, 32'h0000_0000);
    rerun();
    chk("trigger idle", 32'h0000_0001, 32'(trig_n));
    go(cy(24'h000150));
    chk("range first hit", 32'h0000_0001, 32'(sat[8]));
    chk("trigger low", 32'h0000_0000, 32'(trig_n));
    @(posedge ref_clk_i);
    #1;
    chk("trigger held", 32'h0000_0000, 32'(trig_n));
    go(c0);
    chk("trigger released", 32'h0000_0001, 32'(trig_n));
  endtask : t_tail

  initial begin
    c0 = cy(24'h000100);
    repeat (6) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    run_i  <= 1'b1;
    t_regs();
    t_match();
    t_pass();
    t_delay();
    t_actions();
    t_seq();
    t_tail();
    finish_test();
  end
endmodule : test_bus_event_detector
